// ===== inc/pstw_pkg.sv
package pstw_pkg;

    localparam int ADDR_W = 6;
    localparam int DATA_W = 4;

    // register offsets
    localparam logic [5:0] ADDR_TA_FLAG = 6'h01;
    localparam logic [5:0] ADDR_BC_FLAG = 6'h02;
    localparam logic [5:0] ADDR_PORT_FUNC_A = 6'h04;
    localparam logic [5:0] ADDR_SERIAL_CLK = 6'h05;
    localparam logic [5:0] ADDR_TA_CTL = 6'h08;
    localparam logic [5:0] ADDR_TB_CTL = 6'h09;
    localparam logic [5:0] ADDR_TB_LOW = 6'h0a;
    localparam logic [5:0] ADDR_TB_HIGH = 6'h0b;
    localparam logic [5:0] ADDR_TC_CTL = 6'h0d;
    localparam logic [5:0] ADDR_TC_LOW = 6'h0e;
    localparam logic [5:0] ADDR_TC_HIGH = 6'h0f;
    localparam logic [5:0] ADDR_GUARD = 6'h10;

    // field positions
    localparam int TA_FLAG_BIT = 2;
    localparam int TB_FLAG_BIT = 0;
    localparam int TC_FLAG_BIT = 2;
    localparam int AUTO_RELOAD_BIT = 3;
    localparam int TA_SUBCLK_BIT = 3;
    localparam int PORT_EVENT_BIT = 3;
    localparam int GUARD_BIT = 0;

    // values after reset, and the counter top value
    localparam logic [3:0] CTL_RST = 4'h0;
    localparam logic [7:0] RELOAD_RST = 8'h00;
    localparam logic [7:0] COUNT_RST = 8'h00;
    localparam logic [10:0] PSS_RST = 11'h000;
    localparam logic [4:0] PSW_RST = 5'h00;
    localparam logic [2:0] SUBDIV_RST = 3'h0;
    localparam logic [7:0] COUNT_MAX = 8'hff;

    // sub-clock pre-divider last state (input divided by eight)
    localparam logic [2:0] SUBDIV_LAST = 3'h7;
    localparam logic [1:0] SUBDIV_HALF_LAST = 2'h3;

    // mode register settling: cycles from write to effect
    localparam int CTL_SETTLE_CYCLES = 2;

endpackage : pstw_pkg

// ===== logic/pstw_reload_timer.sv
module pstw_reload_timer
(
    input wire logic clock,
    input wire logic rst_n,
    input wire logic [7:0] taps,
    input wire logic ctl_wr,
    input wire logic low_wr,
    input wire logic high_wr,
    input wire logic high_rd,
    input wire logic [pstw_pkg::DATA_W-1:0] wdata,
    output logic [7:0] count,
    output logic [3:0] snap_low,
    output logic wrap
);
    import pstw_pkg::*;

    logic [3:0] ctl_reg;
    logic [3:0] ctl_eff_reg;
    logic [7:0] reload_reg;
    logic [7:0] count_reg;
    logic [3:0] snap_reg;
    logic tick;

    assign tick = taps[ctl_eff_reg[2:0]];
    assign wrap = tick && (count_reg == COUNT_MAX);
    assign count = count_reg;
    assign snap_low = snap_reg;

    // mode write steers the ticks sampled two edges after it
    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            ctl_reg <= CTL_RST;
            ctl_eff_reg <= CTL_RST;
        end
        else
        begin
            if (ctl_wr)
                ctl_reg <= wdata;
            ctl_eff_reg <= ctl_reg;
        end
    end

    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
            reload_reg <= RELOAD_RST;
        else if (low_wr)
            reload_reg[3:0] <= wdata;
        else if (high_wr)
            reload_reg[7:4] <= wdata;
    end

    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
            count_reg <= COUNT_RST;
        else if (high_wr)
            count_reg <= {wdata, reload_reg[3:0]};
        else if (wrap)
            count_reg <= ctl_eff_reg[AUTO_RELOAD_BIT] ? reload_reg : COUNT_RST;
        else if (tick)
            count_reg <= count_reg + 8'h01;
    end

    // high digit read freezes the low digit
    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
            snap_reg <= 4'h0;
        else if (high_rd)
            snap_reg <= count_reg[3:0];
    end

    default clocking cb @(posedge clock);
    endclocking
    default disable iff (!rst_n);

    load_count_a: assert property (high_wr |=> count_reg == reload_reg)
        else $error("reload high write did not load the counter");
    wrap_value_a: assert property (wrap && !high_wr |=>
        count_reg == ($past(ctl_eff_reg[AUTO_RELOAD_BIT]) ? $past(reload_reg) : 8'h00))
        else $error("wrap value wrong");
    mode_settle_a: assert property (ctl_wr ##1 !ctl_wr |=> ctl_eff_reg == $past(wdata, 2))
        else $error("mode write not effective at second cycle");
    count_step_a: assert property (tick && !wrap && !high_wr |=>
        count_reg == 8'($past(count_reg) + 8'h01))
        else $error("counter did not step by one");
    cover_reload_wrap_c: cover property (ctl_eff_reg[AUTO_RELOAD_BIT] && wrap);

endmodule : pstw_reload_timer

// ===== logic/pstw_sync.sv
module pstw_sync
#(
    parameter int WIDTH = 2
)
(
    input wire logic clock,
    input wire logic rst_n,
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);
    logic [WIDTH-1:0] meta_reg;

    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            meta_reg <= '0;
            sync_out <= '0;
        end
        else
        begin
            meta_reg <= async_in;
            sync_out <= meta_reg;
        end
    end

endmodule : pstw_sync

// ===== logic/pstw_top.sv
// Local design decision: the plain strobed port.
module pstw_top
(
    input wire logic clock,
    input wire logic nrst,
    input wire logic [pstw_pkg::ADDR_W-1:0] addr,
    input wire logic [pstw_pkg::DATA_W-1:0] wdata,
    input wire logic wr,
    input wire logic rd,
    output logic [pstw_pkg::DATA_W-1:0] rdata,
    input wire logic stop_mode,
    input wire logic watch_mode,
    input wire logic subclock_osc_input,
    input wire logic event_input_pin_n,
    output logic timer_a_overflow_flag,
    output logic timer_b_overflow_flag,
    output logic timer_c_overflow_flag,
    output logic guard_arm_flag,
    output logic mcu_reset_req,
    output logic serial_clock_tick
);
    import pstw_pkg::*;

    logic [1:0] rst_pipe_reg;
    logic rst_n;
    logic [1:0] pin_sync;
    logic x1_prev_reg;
    logic event_prev_reg;
    logic x1_edge;
    logic event_tick;
    logic [10:0] pss_reg;
    logic pss_run;
    logic [11:1] pss_tick;
    logic [2:0] subdiv_reg;
    logic sub_tick;
    logic half_sub_tick;
    logic [4:0] psw_reg;
    logic [3:0] ta_ctl_reg;
    logic [3:0] port_func_a_reg;
    logic [3:0] serial_clk_reg;
    logic [7:0] ta_count_reg;
    logic ta_tick;
    logic ta_clear;
    logic ta_wrap;
    logic ta_flag_reg;
    logic tb_flag_reg;
    logic tc_flag_reg;
    logic guard_reg;
    logic mcu_reset_reg;
    logic [7:0] taps_b;
    logic [7:0] taps_c;
    logic [7:0] tb_count;
    logic [7:0] tc_count;
    logic [3:0] tb_snap;
    logic [3:0] tc_snap;
    logic tb_wrap;
    logic tc_wrap;
    logic [3:0] rd_mux;

    // reset release through two flip-flops
    always_ff @(posedge clock or negedge nrst)
    begin
        if (!nrst)
            rst_pipe_reg <= 2'h0;
        else
            rst_pipe_reg <= {rst_pipe_reg[0], 1'b1};
    end
    assign rst_n = rst_pipe_reg[1];

    pstw_sync #(.WIDTH(2)) u_pin_sync
    (
        .clock(clock),
        .rst_n(rst_n),
        .async_in({event_input_pin_n, subclock_osc_input}),
        .sync_out(pin_sync)
    );

    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            x1_prev_reg <= 1'b0;
            event_prev_reg <= 1'b1;
        end
        else
        begin
            x1_prev_reg <= pin_sync[0];
            event_prev_reg <= pin_sync[1];
        end
    end

    assign x1_edge = pin_sync[0] && !x1_prev_reg;
    assign event_tick = port_func_a_reg[PORT_EVENT_BIT] && event_prev_reg && !pin_sync[1];

    // system prescaler
    assign pss_run = !stop_mode && !watch_mode;

    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
            pss_reg <= PSS_RST;
        else if (pss_run)
            pss_reg <= pss_reg + 11'h001;
    end

    // divide-by-2^k tap fires as the low k bits roll over
    genvar k;
    generate
        for (k = 1; k <= 11; k++)
        begin : g_pss_tap
            assign pss_tick[k] = pss_run && (&pss_reg[k-1:0]);
        end
    endgenerate

    // sub-clock divided by eight, then five-bit prescaler
    assign sub_tick = x1_edge && (subdiv_reg == SUBDIV_LAST);
    assign half_sub_tick = x1_edge && (subdiv_reg[1:0] == SUBDIV_HALF_LAST);
    assign ta_clear = ta_ctl_reg[TA_SUBCLK_BIT] && (ta_ctl_reg[2:1] == 2'h3);

    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
            subdiv_reg <= SUBDIV_RST;
        else if (x1_edge)
            subdiv_reg <= subdiv_reg + 3'h1;
    end

    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
            psw_reg <= PSW_RST;
        else if (ta_clear)
            psw_reg <= PSW_RST;
        else if (sub_tick)
            psw_reg <= psw_reg + 5'h01;
    end

    // timer A input selection
    always_comb
    begin
        ta_tick = 1'b0;
        if (!ta_ctl_reg[TA_SUBCLK_BIT])
        begin
            case (ta_ctl_reg[2:0])
                3'h0: ta_tick = pss_tick[11];
                3'h1: ta_tick = pss_tick[10];
                3'h2: ta_tick = pss_tick[9];
                3'h3: ta_tick = pss_tick[7];
                3'h4: ta_tick = pss_tick[5];
                3'h5: ta_tick = pss_tick[3];
                3'h6: ta_tick = pss_tick[2];
                default: ta_tick = pss_tick[1];
            endcase
        end
        else
        begin
            case (ta_ctl_reg[2:0])
                3'h0: ta_tick = sub_tick && (&psw_reg[4:0]);
                3'h1: ta_tick = sub_tick && (&psw_reg[3:0]);
                3'h2: ta_tick = sub_tick && (&psw_reg[2:0]);
                3'h3: ta_tick = sub_tick && psw_reg[0];
                3'h4: ta_tick = half_sub_tick;
                default: ta_tick = 1'b0;
            endcase
        end
    end

    assign ta_wrap = ta_tick && (ta_count_reg == COUNT_MAX);

    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
            ta_count_reg <= COUNT_RST;
        else if (ta_clear)
            ta_count_reg <= COUNT_RST;
        else if (ta_tick)
            ta_count_reg <= ta_count_reg + 8'h01;
    end

    // tap tables for timer B, timer C and serial clock
    assign taps_b = {event_tick, pss_tick[1], pss_tick[2], pss_tick[3],
                     pss_tick[5], pss_tick[7], pss_tick[9], pss_tick[11]};
    assign taps_c = {pss_tick[1], pss_tick[2], pss_tick[3], pss_tick[5],
                     pss_tick[7], pss_tick[9], pss_tick[10], pss_tick[11]};
    assign serial_clock_tick = taps_c[serial_clk_reg[2:0]];

    pstw_reload_timer u_timer_b
    (
        .clock(clock),
        .rst_n(rst_n),
        .taps(taps_b),
        .ctl_wr(wr && addr == ADDR_TB_CTL),
        .low_wr(wr && addr == ADDR_TB_LOW),
        .high_wr(wr && addr == ADDR_TB_HIGH),
        .high_rd(rd && addr == ADDR_TB_HIGH),
        .wdata(wdata),
        .count(tb_count),
        .snap_low(tb_snap),
        .wrap(tb_wrap)
    );

    pstw_reload_timer u_timer_c
    (
        .clock(clock),
        .rst_n(rst_n),
        .taps(taps_c),
        .ctl_wr(wr && addr == ADDR_TC_CTL),
        .low_wr(wr && addr == ADDR_TC_LOW),
        .high_wr(wr && addr == ADDR_TC_HIGH),
        .high_rd(rd && addr == ADDR_TC_HIGH),
        .wdata(wdata),
        .count(tc_count),
        .snap_low(tc_snap),
        .wrap(tc_wrap)
    );

    // write-only control registers
    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            ta_ctl_reg <= CTL_RST;
            port_func_a_reg <= CTL_RST;
            serial_clk_reg <= CTL_RST;
        end
        else if (wr)
        begin
            if (addr == ADDR_TA_CTL)
                ta_ctl_reg <= wdata;
            if (addr == ADDR_PORT_FUNC_A)
                port_func_a_reg <= wdata;
            if (addr == ADDR_SERIAL_CLK)
                serial_clk_reg <= wdata;
        end
    end

    // overflow flags: writing 0 clears, a same-cycle overflow wins
    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
            ta_flag_reg <= 1'b0;
        else if (ta_wrap)
            ta_flag_reg <= 1'b1;
        else if (wr && addr == ADDR_TA_FLAG && !wdata[TA_FLAG_BIT])
            ta_flag_reg <= 1'b0;
    end

    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
            tb_flag_reg <= 1'b0;
        else if (tb_wrap)
            tb_flag_reg <= 1'b1;
        else if (wr && addr == ADDR_BC_FLAG && !wdata[TB_FLAG_BIT])
            tb_flag_reg <= 1'b0;
    end

    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
            tc_flag_reg <= 1'b0;
        else if (tc_wrap)
            tc_flag_reg <= 1'b1;
        else if (wr && addr == ADDR_BC_FLAG && !wdata[TC_FLAG_BIT])
            tc_flag_reg <= 1'b0;
    end

    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
            guard_reg <= 1'b0;
        else if (wr && addr == ADDR_GUARD && wdata[GUARD_BIT])
            guard_reg <= 1'b1;
    end

    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
            mcu_reset_reg <= 1'b0;
        else
            mcu_reset_reg <= tc_wrap && guard_reg;
    end

    assign timer_a_overflow_flag = ta_flag_reg;
    assign timer_b_overflow_flag = tb_flag_reg;
    assign timer_c_overflow_flag = tc_flag_reg;
    assign guard_arm_flag = guard_reg;
    assign mcu_reset_req = mcu_reset_reg;

    // read mux; write-only and unmapped addresses read zero
    always_comb
    begin
        rd_mux = 4'h0;
        case (addr)
            ADDR_TA_FLAG: rd_mux[TA_FLAG_BIT] = ta_flag_reg;
            ADDR_BC_FLAG:
            begin
                rd_mux[TB_FLAG_BIT] = tb_flag_reg;
                rd_mux[TC_FLAG_BIT] = tc_flag_reg;
            end
            ADDR_TB_LOW: rd_mux = tb_snap;
            ADDR_TB_HIGH: rd_mux = tb_count[7:4];
            ADDR_TC_LOW: rd_mux = tc_snap;
            ADDR_TC_HIGH: rd_mux = tc_count[7:4];
            ADDR_GUARD: rd_mux[GUARD_BIT] = guard_reg;
            default: rd_mux = 4'h0;
        endcase
    end

    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
            rdata <= 4'h0;
        else if (rd)
            rdata <= rd_mux;
        else
            rdata <= 4'h0;
    end

    default clocking cb @(posedge clock);
    endclocking
    default disable iff (!rst_n);

    pss_count_a: assert property (pss_run |=> pss_reg == 11'($past(pss_reg) + 11'h001))
        else $error("system prescaler did not advance");
    pss_hold_a: assert property (!pss_run |=> $stable(pss_reg))
        else $error("system prescaler ran in stop or watch");
    ta_wrap_a: assert property (ta_wrap && !ta_clear |=> ta_flag_reg && ta_count_reg == 8'h00)
        else $error("timer A wrap wrong");
    ta_clear_a: assert property (ta_clear |=> ta_count_reg == 8'h00 && psw_reg == 5'h00)
        else $error("time-base clear did not zero counters");
    guard_sticky_a: assert property (guard_reg |=> guard_reg)
        else $error("guard arm flag dropped without reset");
    guard_reset_a: assert property (tc_wrap && guard_reg |=> mcu_reset_req)
        else $error("armed timer C overflow did not reset");
    no_reset_a: assert property (!guard_reg |=> !mcu_reset_req)
        else $error("reset request without guard armed");
    prio_flag_a: assert property (tb_wrap && wr && addr == ADDR_TB_HIGH |=> tb_flag_reg)
        else $error("overflow flag lost under reload write");
    split_read_a: assert property (rd && addr == ADDR_TB_HIGH ##1 rd && addr == ADDR_TB_LOW
        |=> rdata == $past(tb_count[3:0], 2))
        else $error("low digit not consistent with high read");
    high_read_a: assert property (rd && addr == ADDR_TC_HIGH |=> rdata == $past(tc_count[7:4]))
        else $error("high digit read wrong");

    cover_ta_wrap_c: cover property (ta_wrap);
    cover_guard_c: cover property (mcu_reset_req);
    cover_event_c: cover property (event_tick && tb_wrap);

endmodule : pstw_top

// ===== sim/test_prescaled_timers_watchdog.sv
module test_prescaled_timers_watchdog;
    timeunit 1ns;
    timeprecision 1ps;
    import pstw_pkg::*;

    typedef struct
    {
        string what;
        logic [3:0] exp;
        logic [3:0] mask;
    } pstw_note_s;

    logic clock;
    logic nrst;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic wr;
    logic rd;
    logic [DATA_W-1:0] rdata;
    logic stop_mode;
    logic watch_mode;
    logic sub_clk;
    logic event_n;
    logic flag_a;
    logic flag_b;
    logic flag_c;
    logic guard;
    logic mcu_reset_req;
    logic serial_clock_tick;
    pstw_note_s notes[$];
    pstw_note_s nt;
    logic rd_seen = 1'b0;
    logic [7:0] v;
    logic [5:0] lo;
    int n_errors = 0;
    int n_checks = 0;
    int n_ser = 0;
    int n_wd = 0;

    initial
    begin
        clock = 1'b0;
        forever #4 clock = ~clock;
    end

    pstw_top u_dut
    (
        .clock(clock),
        .nrst(nrst),
        .addr(addr),
        .wdata(wdata),
        .wr(wr),
        .rd(rd),
        .rdata(rdata),
        .stop_mode(stop_mode),
        .watch_mode(watch_mode),
        .subclock_osc_input(sub_clk),
        .event_input_pin_n(event_n),
        .timer_a_overflow_flag(flag_a),
        .timer_b_overflow_flag(flag_b),
        .timer_c_overflow_flag(flag_c),
        .guard_arm_flag(guard),
        .mcu_reset_req(mcu_reset_req),
        .serial_clock_tick(serial_clock_tick)
    );

    task automatic print_verdict();
        $display("checks %0d errors %0d", n_checks, n_errors);
        if (n_errors == 0 && n_checks > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask : print_verdict

    task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
        n_checks++;
        if (got !== exp)
        begin
            n_errors++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask : check

    // result side: read data stand in the cycle after the strobe
    always @(posedge clock)
    begin
        rd_seen <= rd;
    end

    // pulses are counted mid-cycle, away from the edge that launches them
    always @(negedge clock)
    begin
        if (serial_clock_tick === 1'b1)
            n_ser++;
        if (mcu_reset_req === 1'b1)
            n_wd++;
        if (rd_seen === 1'b1)
        begin
            nt = notes.pop_front();
            check(nt.what, {4'h0, nt.exp & nt.mask}, {4'h0, rdata & nt.mask});
        end
    end

    task automatic wr_reg(input logic [5:0] a, input logic [3:0] d);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        rd <= 1'b0;
        @(posedge clock);
    endtask : wr_reg

    task automatic rd_reg(input string what, input logic [5:0] a, input logic [3:0] e,
                          input logic [3:0] m);
        pstw_note_s n;
        n.what = what;
        n.exp = e;
        n.mask = m;
        notes.push_back(n);
        addr <= a;
        wr <= 1'b0;
        rd <= 1'b1;
        @(posedge clock);
    endtask : rd_reg

    task automatic idle(input int n);
        wr <= 1'b0;
        rd <= 1'b0;
        repeat (n) @(posedge clock);
    endtask : idle

    task automatic load(input logic [5:0] a, input logic [7:0] d);
        wr_reg(a, d[3:0]);
        wr_reg(a + 6'h01, d[7:4]);
    endtask : load

    // high digit first, so the low digit comes from the latch
    task automatic rd_count(input string what, input logic [5:0] a, input logic [7:0] e,
                            input logic [7:0] m);
        rd_reg(what, a + 6'h01, e[7:4], m[7:4]);
        rd_reg(what, a, e[3:0], m[3:0]);
    endtask : rd_count

    // lets the system prescaler run for n cycles, then freezes it again
    task automatic run(input int n);
        stop_mode <= 1'b0;
        idle(n);
        stop_mode <= 1'b1;
        idle(4);
    endtask : run

    task automatic sub_edges(input int n);
        repeat (n)
        begin
            sub_clk <= 1'b1;
            idle(4);
            sub_clk <= 1'b0;
            idle(4);
        end
    endtask : sub_edges

    initial
    begin
        repeat (50000) @(posedge clock);
        n_errors++;
        $display("Error watchdog expected finish seen hang");
        print_verdict();
    end

    initial
    begin
        nrst = 1'b0;
        addr = 6'h00;
        wdata = 4'h0;
        wr = 1'b0;
        rd = 1'b0;
        stop_mode = 1'b1;
        watch_mode = 1'b0;
        sub_clk = 1'b0;
        event_n = 1'b1;
        repeat (10) @(posedge clock);
        nrst <= 1'b1;
        idle(3);
        void'($urandom(19960));
        rd_count("count b rst", ADDR_TB_LOW, COUNT_RST, 8'hff);
        rd_count("count c rst", ADDR_TC_LOW, COUNT_RST, 8'hff);
        rd_reg("flags bc rst", ADDR_BC_FLAG, 4'h0, 4'h5);
        rd_reg("guard rst", ADDR_GUARD, 4'h0, 4'h1);
        rd_reg("ctl a", ADDR_TA_CTL, 4'h0, 4'hf);
        rd_reg("ctl b", ADDR_TB_CTL, 4'h0, 4'hf);
        rd_reg("unmapped", 6'h3f, 4'h0, 4'hf);
        idle(2);
        $display("test reset done");
        for (int i = 0; i < 8; i++)
        begin
            v = 8'($urandom_range(255, 0));
            lo = i[0] ? ADDR_TC_LOW : ADDR_TB_LOW;
            load(lo, v);
            rd_count("reload", lo, v, 8'hff);
        end
        load(ADDR_TB_LOW, 8'h3c);
        rd_reg("latch hi", ADDR_TB_HIGH, 4'h3, 4'hf);
        load(ADDR_TB_LOW, 8'h77);
        rd_reg("latch lo", ADDR_TB_LOW, 4'hc, 4'hf);
        wr_reg(ADDR_TB_LOW, 4'h1);
        rd_count("low only", ADDR_TB_LOW, 8'h77, 8'hff);
        idle(2);
        $display("test digits done");
        wr_reg(ADDR_SERIAL_CLK, 4'h7);
        stop_mode <= 1'b0;
        idle(4);
        n_ser = 0;
        idle(64);
        check("serial ticks run", 8'd32, 8'(n_ser));
        stop_mode <= 1'b1;
        idle(4);
        n_ser = 0;
        idle(32);
        check("serial ticks stop", 8'd0, 8'(n_ser));
        $display("test prescaler done");
        for (int t = 0; t < 2; t++)
        begin
            lo = t[0] ? ADDR_TC_LOW : ADDR_TB_LOW;
            wr_reg(t[0] ? ADDR_TC_CTL : ADDR_TB_CTL, t[0] ? 4'h7 : 4'h6);
            load(lo, COUNT_MAX);
            run(10);
            rd_reg("wrap zero", lo + 6'h01, 4'h0, 4'hf);
            rd_reg("flag set", ADDR_BC_FLAG, 4'h5, t[0] ? 4'h4 : 4'h1);
            check("flag pin", 8'd1, {7'h0, t[0] ? flag_c : flag_b});
            wr_reg(ADDR_BC_FLAG, 4'h0);
            rd_reg("flag clear", ADDR_BC_FLAG, 4'h0, 4'h5);
            wr_reg(t[0] ? ADDR_TC_CTL : ADDR_TB_CTL, t[0] ? 4'hf : 4'he);
            load(lo, COUNT_MAX);
            stop_mode <= 1'b0;
            wr_reg(lo + 6'h01, 4'hf);
            wr_reg(lo + 6'h01, 4'hf);
            run(10);
            rd_count("wrap reload", lo, COUNT_MAX, 8'hff);
        end
        idle(2);
        check("no guard reset", 8'd0, 8'(n_wd));
        $display("test overflow done");
        wr_reg(ADDR_PORT_FUNC_A, 4'h8);
        wr_reg(ADDR_TB_CTL, 4'h7);
        load(ADDR_TB_LOW, 8'hfd);
        wr_reg(ADDR_BC_FLAG, 4'h0);
        repeat (3)
        begin
            event_n <= 1'b0;
            idle(6);
            event_n <= 1'b1;
            idle(6);
        end
        rd_count("event count", ADDR_TB_LOW, 8'h00, 8'hff);
        rd_reg("event flag", ADDR_BC_FLAG, 4'h1, 4'h1);
        check("flag b pin", 8'd1, {7'h0, flag_b});
        idle(2);
        $display("test event done");
        wr_reg(ADDR_TA_CTL, 4'h7);
        stop_mode <= 1'b0;
        idle(600);
        stop_mode <= 1'b1;
        idle(4);
        rd_reg("timer a flag", ADDR_TA_FLAG, 4'h4, 4'h4);
        check("flag a pin", 8'd1, {7'h0, flag_a});
        wr_reg(ADDR_TA_FLAG, 4'h0);
        rd_reg("timer a clear", ADDR_TA_FLAG, 4'h0, 4'h4);
        idle(2);
        check("no guard reset", 8'd0, 8'(n_wd));
        stop_mode <= 1'b0;
        watch_mode <= 1'b1;
        wr_reg(ADDR_TA_CTL, 4'hc);
        sub_edges(1100);
        rd_reg("time base flag", ADDR_TA_FLAG, 4'h4, 4'h4);
        wr_reg(ADDR_TA_CTL, 4'he);
        idle(2);
        wr_reg(ADDR_TA_FLAG, 4'h0);
        sub_edges(1100);
        rd_reg("time base held", ADDR_TA_FLAG, 4'h0, 4'h4);
        stop_mode <= 1'b1;
        watch_mode <= 1'b0;
        idle(2);
        $display("test timer a done");
        wr_reg(ADDR_GUARD, 4'h1);
        rd_reg("guard set", ADDR_GUARD, 4'h1, 4'h1);
        check("guard pin", 8'd1, {7'h0, guard});
        wr_reg(ADDR_GUARD, 4'h0);
        rd_reg("guard kept", ADDR_GUARD, 4'h1, 4'h1);
        wr_reg(ADDR_TC_CTL, 4'hf);
        load(ADDR_TC_LOW, COUNT_MAX);
        run(10);
        check("guard reset", 8'd1, 8'(n_wd != 0));
        nrst <= 1'b0;
        idle(2);
        nrst <= 1'b1;
        idle(3);
        rd_reg("guard after rst", ADDR_GUARD, 4'h0, 4'h1);
        check("guard pin rst", 8'd0, {7'h0, guard});
        wr_reg(ADDR_TC_HIGH, RELOAD_RST[7:4]);
        rd_count("reload after rst", ADDR_TC_LOW, RELOAD_RST, 8'hff);
        rd_reg("flag a after rst", ADDR_TA_FLAG, 4'h0, 4'h4);
        idle(3);
        $display("test guard done");
        print_verdict();
    end
endmodule : test_prescaled_timers_watchdog
